// ===== shared/ext_irq_pkg.sv
/*
  Constants, encodings and register map for the external pin interrupt block.
  Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package ext_irq_pkg;

  localparam int NPIN = 3;

  // register byte offsets
  localparam logic [11:0] OFF_SENSE  = 12'h000;
  localparam logic [11:0] OFF_ENABLE = 12'h004;
  localparam logic [11:0] OFF_FLAG   = 12'h008;
  localparam logic [11:0] OFF_DRIVE  = 12'h00c;
  localparam logic [11:0] OFF_STATE  = 12'h010;

  // sense register fields
  localparam int SENSE_ZERO_LO_POS = 0;
  localparam int SENSE_ZERO_HI_POS = 1;
  localparam int SENSE_ONE_LO_POS  = 2;
  localparam int SENSE_ONE_HI_POS  = 3;
  localparam int EDGE_POL_TWO_POS  = 4;

  // drive register: pin output values in low bits, enables above
  localparam int DRIVE_OE_POS = 4;

  // state register fields
  localparam int STATE_LOW_POS   = 0;
  localparam int STATE_LEVEL_POS = 3;
  localparam int STATE_WAKE_POS  = 8;

  // reset values
  localparam logic [4:0] SENSE_RST  = 5'h00;
  localparam logic [2:0] ENABLE_RST = 3'h0;
  localparam logic [2:0] DRIVE_RST  = 3'h0;

  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL  = 2'h0,
    SENSE_ANY_CHANGE = 2'h1,
    SENSE_FALLING    = 2'h2,
    SENSE_RISING     = 2'h3
  } sense_t;

  localparam logic [2:0] SLEEP_IDLE       = 3'h0;
  localparam logic [2:0] SLEEP_POWER_DOWN = 3'h2;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WDT_PERIOD_NS = 1000;
  localparam int WDT_CYCLES    = WDT_PERIOD_NS / CLK_PERIOD_NS;

  localparam int STARTUP_US_0 = 4;
  localparam int STARTUP_US_1 = 16;
  localparam int STARTUP_US_2 = 64;
  localparam int STARTUP_US_3 = 128;
  localparam int STARTUP_CYC_0 = (STARTUP_US_0 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC_1 = (STARTUP_US_1 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC_2 = (STARTUP_US_2 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC_3 = (STARTUP_US_3 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== hw/pin_sense.sv
/*
  One request pin: two-flop synchroniser, previous-sample edge detector and
  sense-mode decode. Assumes pin is the value seen on the pad, driver included.
*/
`timescale 1ns/1ps
module pin_sense import ext_irq_pkg::*; #(
  parameter bit EDGE_ONLY = 1'b0
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  // pin and configuration
  input  wire logic            pin,
  input  wire ext_irq_pkg::sense_t sense,
  input  wire logic            clk_run,
  // detection
  output logic                 edge_hit,
  output logic                 pin_low
);

  logic sync_meta;
  logic sync_q;
  logic prev;
  logic rise;
  logic fall;
  logic hit;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_meta <= 1'b1;
      sync_q    <= 1'b1;
      prev      <= 1'b1;
    end else begin
      sync_meta <= pin;
      sync_q    <= sync_meta;
      prev      <= sync_q;
    end
  end

  assign rise = sync_q & ~prev; // R15
  assign fall = ~sync_q & prev; // R15

  always_comb begin
    case (sense) // R11
      SENSE_LOW_LEVEL:  hit = 1'b0;
      SENSE_ANY_CHANGE: hit = rise | fall;
      SENSE_FALLING:    hit = fall;
      SENSE_RISING:     hit = rise;
      default:          hit = 1'b0;
    endcase
  end

  // the edge-only pin keeps sensing with the I/O clock stopped
  assign edge_hit = hit & (clk_run | EDGE_ONLY); // R4 R5
  assign pin_low  = ~sync_q & ~EDGE_ONLY; // R2

endmodule

// ===== hw/external_pin_interrupts.sv
/*
  External pin interrupt controller for three request pins, with APB
  registers, sticky flags, level requests and power-down level wake-up.
  Assumes a 20 MHz clock, an APB master and a sleep controller that reports
  sleep state and takes the wake request.
*/
// Behaviour
// R1: an enabled request pin still raises its interrupt while the block drives the pin as an output.
// R2: pins zero and one sense falling edge, rising edge or low level; pin two senses edges only.
// R3: an enabled pin zero or one in low-level mode requests an interrupt for as long as it is low.
// R4: edges on pins zero and one are seen only while the I/O clock runs.
// R5: low levels on pins zero and one and edges on pin two are seen with no I/O clock, for wake-up.
// R6: the I/O clock is stopped in every sleep mode but idle.
// R7: a level wake-up from power-down needs the level on two watchdog clock samples 1 us apart.
// R8: the part wakes once both samples pass, and keeps waking through the start-up time.
// R9: a level gone before start-up ends still wakes the part but raises no level interrupt.
// R10: the outside source holds the level until the wake-up sequence has completed.
// R11: sense select codes 00 low level, 01 any change, 10 falling edge, 11 rising edge.
// R12: the pin two polarity bit selects falling edge at zero and rising edge at one.
// R13: an edge sets the pin flag; the handler or a written one clears it.
// R14: pins zero and one read their flag as clear while in low-level mode.
// R15: edges are found by synchronising each pin and comparing with the previous sample.
`timescale 1ns/1ps
module external_pin_interrupts import ext_irq_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // request pins
  input  wire logic        ext_request_pin_zero_in,
  output logic             ext_request_pin_zero_out,
  output logic             ext_request_pin_zero_oe,
  input  wire logic        ext_request_pin_one_in,
  output logic             ext_request_pin_one_out,
  output logic             ext_request_pin_one_oe,
  input  wire logic        ext_request_pin_two_in,
  output logic             ext_request_pin_two_out,
  output logic             ext_request_pin_two_oe,
  // core side
  input  wire logic [2:0]  handler_ack,
  input  wire logic        sleep_active,
  input  wire logic [2:0]  sleep_mode,
  input  wire logic [1:0]  startup_time_fuses,
  output logic             irq,
  output logic             wake_request
);
  import ext_irq_pkg::*;

  typedef enum logic [1:0] {W_IDLE, W_FIRST, W_SECOND, W_START} wake_state_t;

  logic [4:0]  sense_reg;
  logic [2:0]  enable;
  logic [2:0]  flag;
  logic [2:0]  drive_out;
  logic [2:0]  drive_oe;
  logic [2:0]  pin_in;
  logic [2:0]  pin_seen;
  logic [2:0]  edge_hit;
  logic [2:0]  pin_low;
  logic [2:0]  level_raw;
  logic [2:0]  level_eff;
  logic [2:0]  level_mode;
  logic [2:0]  flag_clr;
  logic [2:0]  flag_read;
  sense_t      sense [NPIN];
  logic        io_clk_run;
  logic        power_down;
  logic        pd_low;
  logic        wake_level;
  logic        wdt_tick;
  logic [4:0]  wdt_cnt;
  logic [11:0] start_cnt;
  logic [11:0] start_load;
  wake_state_t wstate;
  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [31:0] next_prdata;

  assign io_clk_run = !(sleep_active && sleep_mode != SLEEP_IDLE); // R6
  assign power_down = sleep_active && sleep_mode == SLEEP_POWER_DOWN;

  assign pin_in = {ext_request_pin_two_in, ext_request_pin_one_in, ext_request_pin_zero_in};
  // a driven pin reads back the block's own drive, so software can raise a request
  assign pin_seen = (drive_oe & drive_out) | (~drive_oe & pin_in); // R1

  assign sense[0] = sense_t'({sense_reg[SENSE_ZERO_HI_POS], sense_reg[SENSE_ZERO_LO_POS]}); // R11
  assign sense[1] = sense_t'({sense_reg[SENSE_ONE_HI_POS], sense_reg[SENSE_ONE_LO_POS]}); // R11
  assign sense[2] = sense_reg[EDGE_POL_TWO_POS] ? SENSE_RISING : SENSE_FALLING; // R12 R2

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      pin_sense #(
        .EDGE_ONLY (gi == 2)
      ) u_sense (
        .clk      (clk),
        .rst_b    (rst_b),
        .pin      (pin_seen[gi]),
        .sense    (sense[gi]),
        .clk_run  (io_clk_run),
        .edge_hit (edge_hit[gi]),
        .pin_low  (pin_low[gi])
      );
      assign level_mode[gi] = (gi != 2) && sense[gi] == SENSE_LOW_LEVEL; // R2
      assign level_raw[gi]  = enable[gi] & level_mode[gi] & pin_low[gi];
      // during power-down and its start-up, levels only act through the sampler
      assign level_eff[gi]  = level_raw[gi] & ~power_down & (wstate == W_IDLE); // R9
      assign flag_clr[gi]   = (wr && paddr == OFF_FLAG && pwdata[gi]) | handler_ack[gi]; // R13
      assign flag_read[gi]  = flag[gi] & ~level_mode[gi]; // R14
    end
  endgenerate

  // flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag <= 3'h0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (level_mode[i]) begin
          flag[i] <= 1'b0; // R14
        end else if (edge_hit[i]) begin
          flag[i] <= 1'b1; // R13
        end else if (flag_clr[i]) begin
          flag[i] <= 1'b0; // R13
        end
      end
    end
  end

  assign irq = |(flag_read & enable) | (|level_eff); // R3
  assign wake_request = wake_level | (sleep_active && irq); // R5

  // watchdog oscillator tick, one per 1 us
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_cnt <= 5'h00;
    end else if (wdt_cnt == 5'(WDT_CYCLES - 1)) begin
      wdt_cnt <= 5'h00;
    end else begin
      wdt_cnt <= wdt_cnt + 5'h01;
    end
  end
  assign wdt_tick = wdt_cnt == 5'(WDT_CYCLES - 1);

  always_comb begin
    case (startup_time_fuses)
      2'h0:    start_load = 12'(STARTUP_CYC_0);
      2'h1:    start_load = 12'(STARTUP_CYC_1);
      2'h2:    start_load = 12'(STARTUP_CYC_2);
      default: start_load = 12'(STARTUP_CYC_3);
    endcase
  end

  assign pd_low = |level_raw;

  // level wake sampler: two watchdog samples, then the start-up time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wstate    <= W_IDLE;
      start_cnt <= 12'h000;
    end else begin
      case (wstate)
        W_IDLE: begin
          if (power_down && pd_low && wdt_tick) begin
            wstate <= W_FIRST; // R7
          end
        end
        W_FIRST: begin
          if (wdt_tick) begin
            wstate <= pd_low ? W_SECOND : W_IDLE; // R7
          end
        end
        W_SECOND: begin
          if (!pd_low) begin
            wstate <= W_IDLE;
          end else begin
            wstate    <= W_START; // R8
            start_cnt <= start_load;
          end
        end
        W_START: begin
          if (start_cnt == 12'h000) begin
            wstate <= W_IDLE; // R9
          end else begin
            start_cnt <= start_cnt - 12'h001;
          end
        end
        default: wstate <= W_IDLE;
      endcase
    end
  end

  // once accepted, the wake holds until the part has left sleep and the start-up time has ended
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_level <= 1'b0;
    end else if (wstate == W_SECOND && pd_low) begin
      wake_level <= 1'b1; // R8
    end else if (!sleep_active && wstate == W_IDLE) begin
      wake_level <= 1'b0;
    end
  end

  // apb: zero wait states, read data captured in the setup cycle
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && pwrite;
  assign mapped = paddr == OFF_SENSE || paddr == OFF_ENABLE || paddr == OFF_FLAG ||
                  paddr == OFF_DRIVE || paddr == OFF_STATE;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      OFF_SENSE:  next_prdata[4:0] = sense_reg;
      OFF_ENABLE: next_prdata[2:0] = enable;
      OFF_FLAG:   next_prdata[2:0] = flag_read;
      OFF_DRIVE: begin
        next_prdata[2:0] = drive_out;
        next_prdata[DRIVE_OE_POS +: 3] = drive_oe;
      end
      OFF_STATE: begin
        next_prdata[STATE_LOW_POS +: 3]   = ~pin_seen;
        next_prdata[STATE_LEVEL_POS +: 3] = level_raw;
        next_prdata[STATE_WAKE_POS]       = wake_level;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_reg <= SENSE_RST;
      enable    <= ENABLE_RST;
      drive_out <= DRIVE_RST;
      drive_oe  <= DRIVE_RST;
    end else if (wr) begin
      if (paddr == OFF_SENSE) begin
        sense_reg <= pwdata[4:0];
      end
      if (paddr == OFF_ENABLE) begin
        enable <= pwdata[2:0];
      end
      if (paddr == OFF_DRIVE) begin
        drive_out <= pwdata[2:0];
        drive_oe  <= pwdata[DRIVE_OE_POS +: 3];
      end
    end
  end

  assign ext_request_pin_zero_out = drive_out[0];
  assign ext_request_pin_zero_oe  = drive_oe[0];
  assign ext_request_pin_one_out  = drive_out[1];
  assign ext_request_pin_one_oe   = drive_oe[1];
  assign ext_request_pin_two_out  = drive_out[2];
  assign ext_request_pin_two_oe   = drive_oe[2];

  property p_flag_set;
    @(posedge clk) disable iff (!rst_b)
    edge_hit[0] && !level_mode[0] |=> flag[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge did not set flag zero"); // R13

  property p_level_flag_clear;
    @(posedge clk) disable iff (!rst_b)
    level_mode[1] |-> flag_read[1] == 1'b0;
  endproperty
  a_level_flag_clear: assert property (p_level_flag_clear) else $error("flag reads set in level mode"); // R14

  property p_level_irq;
    @(posedge clk) disable iff (!rst_b)
    enable[0] && level_mode[0] && pin_low[0] && !sleep_active && wstate == W_IDLE |-> irq;
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("low level without interrupt"); // R3

  property p_no_edge_asleep;
    @(posedge clk) disable iff (!rst_b)
    sleep_active && sleep_mode != SLEEP_IDLE |-> edge_hit[1:0] == 2'h0;
  endproperty
  a_no_edge_asleep: assert property (p_no_edge_asleep) else $error("clocked edge seen in deep sleep"); // R4

  property p_two_async;
    @(posedge clk) disable iff (!rst_b)
    !io_clk_run && edge_hit[2] |=> flag[2] && (wake_request || !enable[2]);
  endproperty
  a_two_async: assert property (p_two_async) else $error("pin two edge lost in sleep"); // R5

  property p_two_no_level;
    @(posedge clk) disable iff (!rst_b)
    1'b1 |-> level_raw[2] == 1'b0 && pin_low[2] == 1'b0;
  endproperty
  a_two_no_level: assert property (p_two_no_level) else $error("pin two level sensed"); // R2

  property p_two_samples;
    @(posedge clk) disable iff (!rst_b)
    $rose(wake_level) |-> $past(wstate == W_SECOND) && $past(wstate, 2) != W_IDLE;
  endproperty
  a_two_samples: assert property (p_two_samples) else $error("wake accepted without two samples"); // R7

  property p_startup_quiet;
    @(posedge clk) disable iff (!rst_b)
    wstate == W_START |-> level_eff == 3'h0 && wake_request;
  endproperty
  a_startup_quiet: assert property (p_startup_quiet) else $error("level request during start-up"); // R9

  property p_self_drive;
    @(posedge clk) disable iff (!rst_b)
    (enable[0] && level_mode[0] && drive_oe[0] && !drive_out[0] && io_clk_run && wstate == W_IDLE) [*3]
      |-> irq;
  endproperty
  a_self_drive: assert property (p_self_drive) else $error("driven pin raised no request"); // R1

endmodule

// ===== tb/pin_source.sv
/*
  Outside sources on the three request pads.
  Assumes a pull-up on each pad; the block's own drive wins while its enable is high.
*/
`timescale 1ns/1ps
module pin_source (
  // source side
  input  wire logic [2:0] src_val,
  input  wire logic [2:0] src_en,
  // block drive
  input  wire logic [2:0] blk_out,
  input  wire logic [2:0] blk_oe,
  // pad level
  output logic      [2:0] pad
);
  // a source holds its level until released; a released pad floats up
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pad[i] = blk_oe[i] ? blk_out[i] : (src_en[i] ? src_val[i] : 1'h1);
    end
  end
endmodule

// ===== tb/external_pin_interrupts_tb_top.sv
/*
  Self-checking bench for the external pin interrupt block.
  Assumes the pads come from pin_source and the start-up select stays at its shortest.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module external_pin_interrupts_tb_top;
  import ext_irq_pkg::*;
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  src_val = 3'h7;
  logic [2:0]  src_en = 3'h7;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe;
  logic [2:0]  pad;
  logic [2:0]  handler_ack = 3'h0;
  logic        sleep_active = 1'h0;
  logic [2:0]  sleep_mode = 3'h0;
  logic        irq;
  logic        wake_request;
  logic [31:0] rd;
  logic        err;
  int          fail_count = 0;
  int          n_compared = 0;

  always #25 clk = ~clk;

  external_pin_interrupts dut (
    .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_request_pin_zero_in(pad[0]), .ext_request_pin_zero_out(pin_out[0]), .ext_request_pin_zero_oe(pin_oe[0]),
    .ext_request_pin_one_in(pad[1]), .ext_request_pin_one_out(pin_out[1]), .ext_request_pin_one_oe(pin_oe[1]),
    .ext_request_pin_two_in(pad[2]), .ext_request_pin_two_out(pin_out[2]), .ext_request_pin_two_oe(pin_oe[2]),
    .handler_ack(handler_ack), .sleep_active(sleep_active), .sleep_mode(sleep_mode),
    .startup_time_fuses(2'h0), .irq(irq), .wake_request(wake_request)
  );

  pin_source src (.src_val(src_val), .src_en(src_en), .blk_out(pin_out), .blk_oe(pin_oe), .pad(pad));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; waits for pready with no bound of its own
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0);
    `CHK(nm, exp, rd)
  endtask

  task automatic set_pin(input int p, input logic v);
    src_val <= v ? (src_val | (3'h1 << p)) : (src_val & ~(3'h1 << p));
  endtask

  // fall then rise on one pin under one sense word
  task automatic edges(input int p, input logic [4:0] s, input logic ef, input logic er);
    apb(1'h1, OFF_SENSE, {27'h0, s});
    apb(1'h1, OFF_FLAG, 32'h7);
    set_pin(p, 1'h0);
    tick(8);
    `CHK("irq on fall", ef, irq)
    rd_chk(OFF_FLAG, {29'h0, 3'(ef) << p}, "flag on fall");
    apb(1'h1, OFF_FLAG, 32'h7);
    set_pin(p, 1'h1);
    tick(8);
    rd_chk(OFF_FLAG, {29'h0, 3'(er) << p}, "flag on rise");
  endtask

  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd_chk(OFF_SENSE, 32'h0, "sense reset");
    rd_chk(OFF_ENABLE, 32'h0, "enable reset");
    rd_chk(OFF_DRIVE, 32'h0, "drive reset");
    apb(1'h0, 12'h0f0, 32'h0);
    `CHK("unmapped error", 1'h1, err)
    `CHK("ready", 1'h1, pready)
    apb(1'h1, OFF_ENABLE, 32'h7);
    for (int m = 1; m < 4; m++) begin
      edges(0, 5'(m), m != 3, m != 2);
      edges(1, 5'(m << 2), m != 3, m != 2);
    end
    edges(2, 5'h00, 1'h1, 1'h0);
    edges(2, 5'h10, 1'h0, 1'h1);
    // low level on pin zero: request stands, flag stays clear, mask hides it
    apb(1'h1, OFF_SENSE, 32'h0);
    apb(1'h1, OFF_FLAG, 32'h7);
    set_pin(0, 1'h0);
    tick(6);
    `CHK("level irq", 1'h1, irq)
    rd_chk(OFF_FLAG, 32'h0, "level flag");
    apb(1'h1, OFF_ENABLE, 32'h6);
    `CHK("masked irq", 1'h0, irq)
    apb(1'h1, OFF_ENABLE, 32'h7);
    set_pin(0, 1'h1);
    tick(6);
    `CHK("level gone", 1'h0, irq)
    // block drives pin zero low itself, handler clears the flag
    apb(1'h1, OFF_SENSE, 32'h2);
    src_en <= 3'h6;
    apb(1'h1, OFF_DRIVE, 32'h10);
    tick(8);
    `CHK("drive enable", 3'h1, pin_oe)
    rd_chk(OFF_FLAG, 32'h1, "self drive flag");
    handler_ack <= 3'h1;
    @(posedge clk);
    handler_ack <= 3'h0;
    tick(2);
    rd_chk(OFF_FLAG, 32'h0, "handler clear");
    // same self drive under low-level sensing
    apb(1'h1, OFF_SENSE, 32'h0);
    tick(4);
    `CHK("self drive level", 1'h1, irq)
    apb(1'h1, OFF_DRIVE, 32'h0);
    tick(8);
    src_en <= 3'h7;
    // power-down: clocked edges on pin one ignored, pin two still wakes
    apb(1'h1, OFF_SENSE, 32'h08);
    apb(1'h1, OFF_FLAG, 32'h7);
    sleep_mode <= SLEEP_POWER_DOWN;
    sleep_active <= 1'h1;
    set_pin(1, 1'h0);
    tick(8);
    rd_chk(OFF_FLAG, 32'h0, "edge in sleep");
    set_pin(2, 1'h0);
    tick(8);
    `CHK("pin two wake", 1'h1, wake_request)
    src_val <= 3'h7;
    sleep_active <= 1'h0;
    tick(8);
    apb(1'h1, OFF_SENSE, 32'h0);
    apb(1'h1, OFF_FLAG, 32'h7);
    // level wake: a short dip fails the two samples, a held one passes
    sleep_active <= 1'h1;
    set_pin(0, 1'h0);
    tick(3);
    set_pin(0, 1'h1);
    tick(45);
    `CHK("short dip wake", 1'h0, wake_request)
    set_pin(0, 1'h0);
    tick(45);
    `CHK("held wake", 1'h1, wake_request)
    // the core wakes at once; the level goes away before start-up ends
    set_pin(0, 1'h1);
    sleep_active <= 1'h0;
    tick(8);
    rd_chk(OFF_STATE, 32'h100, "wake state");
    tick(100);
    `CHK("gone before start-up", 1'h0, irq)
    rd_chk(OFF_STATE, 32'h0, "wake cleared");
    // held level: quiet during start-up, request once it ends
    sleep_active <= 1'h1;
    set_pin(0, 1'h0);
    tick(45);
    `CHK("second wake", 1'h1, wake_request)
    sleep_active <= 1'h0;
    tick(20);
    `CHK("quiet in start-up", 1'h0, irq)
    tick(80);
    `CHK("held through start-up", 1'h1, irq)
    set_pin(0, 1'h1);
    tick(8);
    final_report;
  end
endmodule
